// *** hdl/dcw_defines.vh ***
`ifndef DCW_DEFINES_VH
`define DCW_DEFINES_VH

// AHB-Lite register byte offsets
`define DCW_REG_WORD     8'h00
`define DCW_REG_CTRL     8'h04
`define DCW_REG_STATUS   8'h08
`define DCW_REG_LAST     8'h0c
`define DCW_REG_FIFO     8'h10
`define DCW_REG_ADDRW    8

// Control register bits
`define DCW_CTRL_START   0
`define DCW_CTRL_PERIPH  1

// Channel control word fields
`define DCW_SW_HI        25
`define DCW_SW_LO        24
`define DCW_RP_HI        17
`define DCW_RP_LO        14
`define DCW_CNT_HI       13
`define DCW_CNT_LO       4
`define DCW_CT_HI        2
`define DCW_CT_LO        0

// Source width codes
`define DCW_SW_BYTE      2'h0
`define DCW_SW_HALF      2'h1
`define DCW_SW_WORD      2'h2
`define DCW_SW_RSVD      2'h3

// Cycle type codes
`define DCW_CT_STOP      3'h0
`define DCW_CT_BASIC     3'h1
`define DCW_CT_AUTO      3'h2
`define DCW_CT_PING      3'h3
`define DCW_CT_MSG_PRI   3'h4
`define DCW_CT_MSG_ALT   3'h5
`define DCW_CT_PSG_PRI   3'h6
`define DCW_CT_PSG_ALT   3'h7

// AHB constants
`define DCW_HTRANS_NSEQ  1'b1
`define DCW_ONES_DATA    32'hffffffff
`define DCW_ZERO32       32'h00000000

`endif

// *** hdl/dcw_fifo.v ***
`timescale 1ns/1ps
`include "dcw_defines.vh"

module dcw_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,     // System clock
  input  wire             resetn,   // Sync reset, active low
  input  wire [WIDTH-1:0] in_data,  // Write data
  input  wire             in_valid, // Write request
  output wire             in_ready, // Not full
  output wire [WIDTH-1:0] out_data, // Head word
  output wire             out_valid,// Not empty
  input  wire             out_ready // Pop
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wptr;
  reg [AW:0]      rptr;
  wire            push;
  wire            pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = !((wptr[AW] != rptr[AW]) &&
                       (wptr[AW-1:0] == rptr[AW-1:0]));
  assign out_valid = (wptr != rptr);
  assign out_data  = mem[rptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and storage update
  always @(posedge mclk) begin
    if (!resetn) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wptr[AW-1:0]] <= in_data;
        wptr              <= wptr + 1'b1;
      end
      if (pop)
        rptr <= rptr + 1'b1;
    end
  end
endmodule

// *** hdl/dcw_decode.v ***
`timescale 1ns/1ps
`include "dcw_defines.vh"

module dcw_decode (
  input  wire [31:0] word,       // Fetched channel control word
  output reg  [2:0]  unit_bytes, // Bytes per transfer, 0 when reserved
  output wire        width_ok,   // Source width usable
  output wire [3:0]  arb_power,  // Arbitration interval exponent
  output wire [10:0] total,      // Transfers remaining, 1..1024
  output wire [2:0]  cycle_type, // Cycle type code
  output wire        active,     // Cycle type is not stop
  output wire        scatter,    // Any scatter-gather code
  output wire        periph_sg,  // Peripheral scatter-gather code
  output wire        use_alt     // Alternate structure selected
);
  wire [1:0] sw;

  assign sw = word[`DCW_SW_HI:`DCW_SW_LO];

  // Width code to bytes; reserved code gives no transfer
  always @* begin
    case (sw)
      `DCW_SW_BYTE: unit_bytes = 3'h1;
      `DCW_SW_HALF: unit_bytes = 3'h2;
      `DCW_SW_WORD: unit_bytes = 3'h4;
      default:      unit_bytes = 3'h0;
    endcase
  end
  assign width_ok   = (sw != `DCW_SW_RSVD);

  assign arb_power  = word[`DCW_RP_HI:`DCW_RP_LO];
  // Count holds N minus one, in transfers
  assign total      = {1'b0, word[`DCW_CNT_HI:`DCW_CNT_LO]} + 11'h001;
  assign cycle_type = word[`DCW_CT_HI:`DCW_CT_LO];
  assign active     = (cycle_type != `DCW_CT_STOP);
  // Top bit marks scatter-gather, middle bit peripheral, low bit alt
  assign scatter    = cycle_type[2];
  assign periph_sg  = (cycle_type == `DCW_CT_PSG_PRI) ||
                      (cycle_type == `DCW_CT_PSG_ALT);
  assign use_alt    = scatter && cycle_type[0];
endmodule

// *** hdl/dcw_channel.v ***
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dcw_defines.vh"
// Functional notes
// - Source width 00 byte, 01 half word, 10 word, 11 reserved unused.
// - The four-bit interval field sets transfers between arbitrations.
// - The ten-bit count holds transfers minus one, 0x3ff meaning 1024.
// - Cycle type 000 stop, 001 basic, 010 autorequest, 011 ping-pong.
// - 100/101 memory scatter-gather, 110/111 peripheral, primary/alt.
// - Before re-arbitrating the word is written back with remaining count.
// - When a cycle ends the stored cycle type is set to 000.
// - Each burst is min(2 to the interval, remaining) transfers.

module dcw_channel #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        mclk,        // 25 MHz system clock
  input  wire        resetn,      // Sync reset, active low
  input  wire [31:0] haddr,       // AHB address
  input  wire [1:0]  htrans,      // AHB transfer type
  input  wire        hwrite,      // AHB write
  input  wire [2:0]  hsize,       // AHB size
  input  wire [31:0] hwdata,      // AHB write data
  input  wire        hsel,        // AHB select
  input  wire        hready,      // AHB bus ready
  output reg  [31:0] hrdata,      // AHB read data
  output reg         hreadyout,   // AHB slave ready
  output reg         hresp,       // AHB response, always OKAY
  output reg         xfer_strobe, // One pulse per data transfer
  output reg  [2:0]  xfer_bytes,  // Bytes of the current transfer
  output reg         arb_strobe,  // Pulse when the channel re-arbitrates
  output reg         done         // Pulse when a cycle completes
);
  // One-hot states
  localparam S_IDLE  = 6'h01;
  localparam S_FETCH = 6'h02;
  localparam S_XFER  = 6'h04;
  localparam S_WBACK = 6'h08;
  localparam S_ARB   = 6'h10;
  localparam S_DONE  = 6'h20;

  reg  [5:0]  state;
  reg  [31:0] stored_word;  // Descriptor copy in system memory
  reg  [31:0] fetched;      // Engine's working copy
  reg  [31:0] last_wb;      // Last value written back
  reg  [10:0] remaining;    // Transfers still to do
  reg  [10:0] burst_left;   // Transfers left before arbitration
  reg         periph;       // Channel serves a peripheral
  reg         start_req;    // Pending start request
  reg         busy;
  reg         ap_valid;
  reg         ap_write;
  reg  [7:0]  ap_addr;
  wire [2:0]  unit_bytes;
  wire        width_ok;
  wire [3:0]  arb_power;
  wire [10:0] total;
  wire [2:0]  cycle_type;
  wire        active;
  wire        scatter;
  wire        periph_sg;
  wire        use_alt;
  wire [10:0] burst_max;
  wire [10:0] burst_len;
  wire        fifo_in_ready;
  wire [31:0] fifo_out_data;
  wire        fifo_out_valid;
  wire        fifo_pop;
  wire        fifo_push;
  wire        ap_take;
  wire [9:0]  next_count;
  reg  [5:0]  next_state;   // Engine state after this edge
  reg  [FIFO_AW:0] fill;    // Mirror of the FIFO level
  wire [FIFO_AW:0] next_fill;
  wire        fifo_wr_take; // FIFO write address phase taken now
  wire        word_wr;      // Data phase of a control word write
  wire        ctrl_wr;      // Data phase of a control register write

  // Every field comes from the fetched copy, not the live descriptor
  dcw_decode u_dec (
    .word       (fetched),
    .unit_bytes (unit_bytes),
    .width_ok   (width_ok),
    .arb_power  (arb_power),
    .total      (total),
    .cycle_type (cycle_type),
    .active     (active),
    .scatter    (scatter),
    .periph_sg  (periph_sg),
    .use_alt    (use_alt)
  );

  // Data written by software streams out one word per transfer
  dcw_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_data   (hwdata),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // Burst size: 2^power clipped at 1024, then at the remaining count
  assign burst_max = (arb_power >= 4'ha) ? 11'h400 :
                     (11'h001 << arb_power);
  assign burst_len = (burst_max < remaining) ? burst_max :
                     remaining;
  assign ap_take   = hsel && hready && htrans[1] == `DCW_HTRANS_NSEQ;
  // A transfer waits for a data word; the FIFO stalls the engine
  assign fifo_pop  = (state == S_XFER) && fifo_out_valid;
  assign fifo_push = ap_valid && ap_write &&
                     ap_addr == `DCW_REG_FIFO && fifo_in_ready;
  assign next_count = remaining[9:0] - 10'h001;
  assign word_wr    = ap_valid && ap_write && ap_addr == `DCW_REG_WORD;
  assign ctrl_wr    = ap_valid && ap_write && ap_addr == `DCW_REG_CTRL;

  // Level after this edge; top bit set means full, as depth is 2^AW
  assign next_fill    = fill + {{FIFO_AW{1'b0}}, fifo_push} -
                        {{FIFO_AW{1'b0}}, fifo_pop};
  assign fifo_wr_take = ap_take && hwrite &&
                        haddr[`DCW_REG_ADDRW-1:0] == `DCW_REG_FIFO;

  // Level mirror lets a write wait from its first data cycle
  always @(posedge mclk) begin
    if (!resetn)
      fill <= {(FIFO_AW+1){1'b0}};
    else
      fill <= next_fill;
  end

  // AHB address phase capture; FIFO writes stall while full
  always @(posedge mclk) begin
    if (!resetn) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (ap_valid && ap_write && ap_addr == `DCW_REG_FIFO &&
          !fifo_in_ready) begin
        hreadyout <= 1'b0;
      end else begin
        // Ready is a register, so a write meeting a full FIFO must
        // be held low already in the cycle after its address phase
        hreadyout <= !(fifo_wr_take && next_fill[FIFO_AW]);
        ap_valid  <= ap_take;
        ap_write  <= hwrite;
        ap_addr   <= haddr[`DCW_REG_ADDRW-1:0];
      end
    end
  end

  // Read data, chosen during the address phase for a wait-free read
  always @(posedge mclk) begin
    if (!resetn) begin
      hrdata <= `DCW_ZERO32;
    end else if (ap_take && !hwrite) begin
      case (haddr[`DCW_REG_ADDRW-1:0])
        `DCW_REG_WORD:   hrdata <= stored_word;
        `DCW_REG_CTRL:   hrdata <= {30'h0, periph, 1'b0};
        `DCW_REG_STATUS: hrdata <= {9'h0, fifo_out_valid, fifo_in_ready,
                                    busy, state, remaining, use_alt,
                                    periph_sg, scatter};
        `DCW_REG_LAST:   hrdata <= last_wb;
        default:         hrdata <= `DCW_ZERO32;
      endcase
    end
  end

  // Next state of the channel engine
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start_req)
          next_state = S_FETCH;
      end
      S_FETCH: begin
        next_state = S_ARB;
      end
      S_ARB: begin
        // Stop code or reserved width ends with no transfer
        if (!active || !width_ok)
          next_state = S_DONE;
        else
          next_state = S_XFER;
      end
      S_XFER: begin
        // Last transfer ends the cycle; a spent burst writes back first
        if (fifo_pop && remaining == 11'h001)
          next_state = S_DONE;
        else if (fifo_pop && burst_left == 11'h001)
          next_state = S_WBACK;
      end
      S_WBACK: begin
        next_state = S_ARB;
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge mclk) begin
    if (!resetn)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // Software control; a fresh start wins over clearing a taken one,
  // and a start while busy stays pending until the engine is idle
  always @(posedge mclk) begin
    if (!resetn) begin
      periph    <= 1'b0;
      start_req <= 1'b0;
    end else begin
      if (ctrl_wr)
        periph <= hwdata[`DCW_CTRL_PERIPH];
      if (ctrl_wr && hwdata[`DCW_CTRL_START])
        start_req <= 1'b1;
      else if (state == S_IDLE)
        start_req <= 1'b0;
    end
  end

  // Busy from the taken start until the completion pulse
  always @(posedge mclk) begin
    if (!resetn)
      busy <= 1'b0;
    else if (state == S_IDLE && start_req)
      busy <= 1'b1;
    else if (state == S_DONE)
      busy <= 1'b0;
  end

  // Working copy and counters
  always @(posedge mclk) begin
    if (!resetn) begin
      fetched    <= `DCW_ZERO32;
      remaining  <= 11'h000;
      burst_left <= 11'h000;
    end else begin
      case (state)
        S_FETCH: begin
          fetched   <= stored_word;
          remaining <= {1'b0, stored_word[`DCW_CNT_HI:`DCW_CNT_LO]} +
                       11'h001;
        end
        S_ARB: begin
          burst_left <= burst_len;
        end
        S_XFER: begin
          // A transfer waits for a data word, so the FIFO paces it
          if (fifo_pop) begin
            remaining  <= remaining - 11'h001;
            burst_left <= burst_left - 11'h001;
          end
        end
        default: begin
          remaining <= remaining;
        end
      endcase
    end
  end

  // Descriptor copy in memory; software may only write it while idle
  always @(posedge mclk) begin
    if (!resetn) begin
      stored_word <= `DCW_ZERO32;
      last_wb     <= `DCW_ZERO32;
    end else begin
      case (state)
        S_WBACK: begin
          // Count now reflects transfers still outstanding
          stored_word[`DCW_CNT_HI:`DCW_CNT_LO] <= next_count;
          last_wb <= {stored_word[31:`DCW_RP_LO], next_count,
                      stored_word[`DCW_CNT_LO-1:0]};
        end
        S_DONE: begin
          // Invalidate so the cycle is not replayed
          stored_word[`DCW_CT_HI:`DCW_CT_LO] <= `DCW_CT_STOP;
          last_wb <= {stored_word[31:`DCW_CT_HI+1],
                      `DCW_CT_STOP};
        end
        default: begin
          if (word_wr && !busy)
            stored_word <= hwdata; // Reserved bits stored, never used
        end
      endcase
    end
  end

  // Write-back and completion pulses last one cycle; the transfer strobe is high one cycle per pop, back to back within a burst while the FIFO holds data
  always @(posedge mclk) begin
    if (!resetn) begin
      xfer_strobe <= 1'b0;
      xfer_bytes  <= 3'h0;
      arb_strobe  <= 1'b0;
      done        <= 1'b0;
    end else begin
      xfer_strobe <= fifo_pop;
      arb_strobe  <= (state == S_WBACK);
      done        <= (state == S_DONE);
      if (fifo_pop)
        xfer_bytes <= unit_bytes;
    end
  end
endmodule

// *** testbench/dcw_sw_model.sv ***
`timescale 1ns/1ps
// Software side: prepares a descriptor control word as a driver must
module dcw_sw_model (
  input  logic [1:0]  src_w,  // Source width code
  input  logic [3:0]  power,  // Arbitration exponent
  input  logic [9:0]  cnt_m1, // Transfers minus one
  input  logic [2:0]  ctype,  // Cycle type
  output logic [31:0] word    // Prepared word
);
  // Spare bits zero, destination width mirrors the source width
  // The stimulus already zeroes the exponent for peripheral codes
  assign word = {2'h2, src_w, 2'h2, src_w, 6'h00, power, cnt_m1, 1'b0,
                 ctype};
endmodule

// *** testbench/dcw_channel_asserts.sv ***
`timescale 1ns/1ps
module dcw_channel_asserts (
  input logic       mclk,        // Clock
  input logic       resetn,      // Reset, active low
  input logic [1:0] htrans,      // Transfer type
  input logic       hwrite,      // Write
  input logic       hsel,        // Select
  input logic       hready,      // Bus ready
  input logic       hreadyout,   // Slave ready
  input logic       hresp,       // Response
  input logic       xfer_strobe, // Transfer pulse
  input logic [2:0] xfer_bytes,  // Transfer size
  input logic       arb_strobe,  // Write-back pulse
  input logic       done         // Cycle end pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Slave never answers with an error
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_width_legal: assert property (
    xfer_strobe |-> xfer_bytes inside {3'h1, 3'h2, 3'h4})
    else $error("illegal transfer size");
  // Size comes from the fetched copy, so it cannot drift within a run
  a_bytes_steady: assert property (
    xfer_strobe && $past(xfer_strobe) |-> $stable(xfer_bytes))
    else $error("transfer size changed");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_quiet: assert property (
    done |=> !xfer_strobe ##1 !xfer_strobe)
    else $error("transfer after completion");
  a_wback_pulse: assert property (arb_strobe |=> !arb_strobe)
    else $error("write-back pulse too long");
  a_wback_follows: assert property (
    arb_strobe |-> $past(xfer_strobe) || $past(xfer_strobe, 2) ||
    $past(xfer_strobe, 3))
    else $error("write-back without a burst");
  a_read_ready: assert property (
    hsel && hready && htrans[1] && !hwrite |=> hreadyout)
    else $error("read not answered at once");
  a_ready_reset: assert property ($rose(resetn) |-> hreadyout)
    else $error("not ready after reset");
  c_done: cover property (done);
  c_wback: cover property (arb_strobe);
  c_back2back: cover property (xfer_strobe && $past(xfer_strobe));
endmodule
bind dcw_channel dcw_channel_asserts i_chk (.mclk(mclk), .resetn(resetn),
  .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .xfer_strobe(xfer_strobe),
  .xfer_bytes(xfer_bytes), .arb_strobe(arb_strobe), .done(done));

// *** testbench/dcw_channel_tb_top.sv ***
`timescale 1ns/1ps
`include "dcw_defines.vh"
module dcw_channel_tb_top;
  localparam logic [31:0] A_WORD = {24'h0, `DCW_REG_WORD};
  localparam logic [31:0] A_CTRL = {24'h0, `DCW_REG_CTRL};
  localparam logic [31:0] A_STAT = {24'h0, `DCW_REG_STATUS};
  localparam logic [31:0] A_LAST = {24'h0, `DCW_REG_LAST};
  localparam logic [31:0] A_FIFO = {24'h0, `DCW_REG_FIFO};
  logic        mclk, resetn, hwrite, hsel, rd_phase, hreadyout, hresp;
  logic        xfer_strobe, arb_strobe, done;
  logic [31:0] haddr, hwdata, hrdata, sw_word, wd;
  logic [1:0]  htrans, sw_w;
  logic [2:0]  sw_ct, xfer_bytes;
  logic [3:0]  sw_r;
  logic [9:0]  sw_m;
  logic [63:0] rq[$];
  logic [63:0] pend;
  logic [2:0]  bq[$];
  int          uq[$];
  int          error_cnt, samples_checked, nxf, done_cnt, i;

  dcw_channel i_dut (.mclk(mclk), .resetn(resetn), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .xfer_strobe(xfer_strobe),
    .xfer_bytes(xfer_bytes), .arb_strobe(arb_strobe), .done(done));
  dcw_sw_model i_sw (.src_w(sw_w), .power(sw_r), .cnt_m1(sw_m),
    .ctype(sw_ct), .word(sw_word));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task timeout;
    error_cnt++;
    $display("wait limit used up at %0t", $time);
    complete_run;
  endtask

  // Bounded wait for the slave to take or answer a phase
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 400);
    if (hreadyout !== 1'b1) timeout;
  endtask

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= !wr;
    wait_rdy;
    rd_phase <= 1'b0;
  endtask

  // Expected read value is noted with its mask before the read goes out
  task rdchk(input logic [31:0] a, input logic [31:0] e,
             input logic [31:0] m);
    rq.push_back({m, e & m});
    ahb(1'b0, a, 32'h0);
  endtask

  // One full cycle: expected sizes and burst lengths noted first
  task run(input logic [1:0] w, input logic [3:0] r, input logic [9:0] m,
           input logic [2:0] ct);
    int n, rem, b, lastb, k, j;
    logic [2:0] sg;
    if (ct[2:1] == 2'h3) r = 4'h0;
    sw_w = w;
    sw_r = r;
    sw_m = m;
    sw_ct = ct;
    #1;
    wd = sw_word;
    ahb(1'b1, A_WORD, wd);
    n = (ct == 3'h0 || w == 2'h3) ? 0 : m + 1;
    rem = n;
    lastb = 0;
    if (n == 0) uq.push_back(0);
    while (rem > 0) begin
      b = ((1 << r) < rem) ? (1 << r) : rem;
      uq.push_back(b);
      rem -= b;
      if (rem > 0) lastb = rem;
    end
    repeat (n) bq.push_back(3'h1 << w);
    for (j = 0; j < n && j < 16; j++) ahb(1'b1, A_FIFO, $urandom);
    if (n == 16) rdchk(A_STAT, 32'h00400000, 32'h00600000);
    k = done_cnt;
    ahb(1'b1, A_CTRL, 32'h1);
    for (j = 16; j < n; j++) ahb(1'b1, A_FIFO, $urandom);
    j = 0;
    while (done_cnt == k && j < 3000) begin
      @(posedge mclk);
      j++;
    end
    if (done_cnt == k) timeout;
    rdchk(A_WORD, wd & 32'hffffc000, 32'hffffc007);
    if (lastb > 0) rdchk(A_LAST, (lastb - 1) << 4, 32'h3ff0);
    // Idle, FIFO drained, and the scatter-gather decode of the copy
    sg = {ct[2] & ct[0], ct[2] & ct[1], ct[2]};
    rdchk(A_STAT, {11'h001, 18'h0, sg}, 32'h00700007);
    chk(bq.size(), 0);
    $display("test cycle type %0d count %0d ended", ct, n);
  endtask

  // Watcher: takes the oldest note off each queue as results appear
  always @(posedge mclk) begin
    if (rd_phase && hreadyout) begin
      pend = rq.pop_front();
      chk(hrdata & pend[63:32], pend[31:0]);
    end
    if (xfer_strobe) begin
      chk(xfer_bytes, bq.pop_front());
      nxf++;
    end
    if (arb_strobe || done) begin
      chk(nxf, uq.pop_front());
      nxf = 0;
    end
    if (done) done_cnt++;
  end

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    rd_phase = 1'b0;
    {sw_w, sw_r, sw_m, sw_ct} = '0;
    void'($urandom(27321));
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    // Unmapped place reads zero; the word is plain read-write
    rdchk(32'h40, 32'h0, 32'hffffffff);
    wd = $urandom;
    ahb(1'b1, A_WORD, wd);
    rdchk(A_WORD, wd, 32'hffffffff);
    $display("test registers ended");
    for (i = 0; i < 8; i++) run(2'h2, 4'h1, 10'h4, i[2:0]);
    for (i = 0; i < 4; i++) run(i[1:0], 4'h0, 10'h2, 3'h1);
    run(2'h1, 4'h2, 10'h00f, 3'h2);
    run(2'h2, 4'h9, 10'h3ff, 3'h2);
    repeat (6) run(2'($urandom % 3), 4'($urandom % 5),
                   10'($urandom % 40), 3'(1 + $urandom % 7));
    complete_run;
  end
endmodule
